// ### core/rtc_timekeeping_core.v
// Timekeeping core: source divider, lock, five count registers.
// Assumes a synchronous 8-bit I/O bus; source pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_core_regs.vh"
module rtc_timekeeping_core #(
  parameter XTAL_DIV = `XTAL_DIV
) (
  input  wire        MCLK,
  input  wire        ARST_N,
  input  wire        OSC_OUTPUT_PIN,
  input  wire        IO_SEL,
  input  wire        IO_WR,
  input  wire        IO_RD,
  input  wire [15:0] IO_ADDR,
  input  wire [7:0]  IO_WDATA,
  output reg  [7:0]  IO_RDATA,
  output reg         ALARM_CLEAR
);
  // ========================================================
  // Registers
  reg  [7:0]  s_count_reg;
  reg  [7:0]  m_count_reg;
  reg  [7:0]  hour_count_reg;
  reg  [3:0]  weekday_count_reg;
  reg  [7:0]  monthday_count_reg;
  reg         unlock_q;
  reg         src_line_q;
  reg         line60_q;
  reg         dec_en_q;
  reg  [2:0]  pin_sync_q;
  reg         pin_seen_q;
  reg  [15:0] div_q;
  reg         tick_q;
  wire        wr_go  = IO_SEL & IO_WR;
  wire        rd_go  = IO_SEL & IO_RD;
  wire        ctl_wr = wr_go && IO_ADDR == `CLK_CTRL_ADDR;
  wire        cnt_wr = wr_go & unlock_q;
  // ========================================================
  // Source edge detect: three stages, rising edge counts when 2 and 3 agree
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_sync_q <= 3'h0;
      pin_seen_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], OSC_OUTPUT_PIN};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_seen_q <= pin_sync_q[2];
      end
    end
  end
  wire src_edge = (pin_sync_q[1] == pin_sync_q[2]) &
                  pin_sync_q[2] & ~pin_seen_q;
  // ========================================================
  // Divider, matched to the source
  wire [15:0] div_top = !src_line_q ? XTAL_DIV[15:0] - 16'h0001 :
                        line60_q ? 16'h003B : 16'h0031;
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (ctl_wr || unlock_q) begin
        div_q <= 16'h0000;
      end else if (src_edge) begin
        if (div_q >= div_top) begin
          div_q  <= 16'h0000;
          tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 16'h0001;
        end
      end
    end
  end
  // ========================================================
  // Field limits per format
  wire [7:0] s_max   = dec_en_q ? 8'h59 : 8'h3B;
  wire [7:0] h_max   = dec_en_q ? 8'h23 : 8'h17;
  wire [7:0] dom_max = dec_en_q ? 8'h31 : 8'h1F;
  wire [7:0] s_nxt, m_nxt, h_nxt, w_nxt, d_nxt;
  wire       s_wr, m_wr, h_wr, w_wr, d_wr;
  rtc_field_inc u_sec (.cur(s_count_reg), .dec_en(dec_en_q),
    .min_val(8'h00), .max_val(s_max), .nxt(s_nxt), .wrap(s_wr));
  rtc_field_inc u_min (.cur(m_count_reg), .dec_en(dec_en_q),
    .min_val(8'h00), .max_val(s_max), .nxt(m_nxt), .wrap(m_wr));
  rtc_field_inc u_hr (.cur(hour_count_reg), .dec_en(dec_en_q),
    .min_val(8'h00), .max_val(h_max), .nxt(h_nxt), .wrap(h_wr));
  rtc_field_inc u_wd (.cur({4'h0, weekday_count_reg}), .dec_en(dec_en_q),
    .min_val(8'h01), .max_val(8'h07), .nxt(w_nxt), .wrap(w_wr));
  rtc_field_inc u_md (.cur(monthday_count_reg), .dec_en(dec_en_q),
    .min_val(8'h01), .max_val(dom_max), .nxt(d_nxt), .wrap(d_wr));
  // ========================================================
  // Counts: no reset, so they survive system reset
  // Month length needs month and year, kept outside this core
  always @(posedge MCLK) begin
    if (cnt_wr) begin
      if (IO_ADDR == `S_COUNT_ADDR)    s_count_reg        <= IO_WDATA;
      if (IO_ADDR == `M_COUNT_ADDR)    m_count_reg        <= IO_WDATA;
      if (IO_ADDR == `HOUR_COUNT_ADDR) hour_count_reg     <= IO_WDATA;
      if (IO_ADDR == `WEEKDAY_ADDR)    weekday_count_reg  <= IO_WDATA[3:0];
      if (IO_ADDR == `MONTHDAY_ADDR)   monthday_count_reg <= IO_WDATA;
    end else if (tick_q && !unlock_q) begin
      s_count_reg <= s_nxt;
      if (s_wr) m_count_reg <= m_nxt;
      if (s_wr && m_wr) hour_count_reg <= h_nxt;
      if (s_wr && m_wr && h_wr) begin
        weekday_count_reg  <= w_nxt[3:0];
        monthday_count_reg <= d_nxt;
      end
    end
  end
  // ========================================================
  // Clock control; reset leaves it locked and counting
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      unlock_q   <= 1'b0;
      src_line_q <= 1'b0;
      line60_q   <= 1'b0;
      dec_en_q   <= 1'b0;
    end else if (ctl_wr) begin
      unlock_q   <= IO_WDATA[`CTRL_UNLOCK_BIT];
      src_line_q <= IO_WDATA[`CTRL_SRC_BIT];
      line60_q   <= IO_WDATA[`CTRL_LINE60_BIT];
      dec_en_q   <= IO_WDATA[`CTRL_DEC_BIT];
    end
  end
  // ========================================================
  // Read side
  reg [7:0] rd_d;
  always @* begin
    case (IO_ADDR)
      `S_COUNT_ADDR:    rd_d = s_count_reg;
      `M_COUNT_ADDR:    rd_d = m_count_reg;
      `HOUR_COUNT_ADDR: rd_d = hour_count_reg;
      `WEEKDAY_ADDR:    rd_d = {4'h0, weekday_count_reg};
      `MONTHDAY_ADDR:   rd_d = monthday_count_reg;
      `CLK_CTRL_ADDR:   rd_d = {3'h0, src_line_q, line60_q, dec_en_q,
                                1'b0, unlock_q};
      default:          rd_d = 8'h00;
    endcase
  end
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IO_RDATA    <= 8'h00;
      ALARM_CLEAR <= 1'b0;
    end else begin
      IO_RDATA    <= rd_go ? rd_d : 8'h00;
      ALARM_CLEAR <= rd_go && IO_ADDR == `CLK_CTRL_ADDR;
    end
  end
endmodule // rtc_timekeeping_core
`default_nettype wire

// ### core/rtc_core_regs.vh
// Constants for the timekeeping core: offsets, fields, counts.
// Assumes an 8-bit I/O bus with a 16-bit address.
// What this block does
// - Count from 32 kHz crystal or 50/60 Hz line input, divider per source.
// - Any write to the clock control register resets the divider.
// - After power-down reset counts are undefined and alarms disabled.
// - Clearing the unlock bit resets then enables the divider.
// - Unlock bit 1: counting stops, counts are read/write.
// - Unlock bit 0: counting runs, count writes are ignored.
// - System reset leaves the clock locked and counting.
// - Count registers keep their values across system reset.
// - Decimal enable 0 gives binary, 1 gives packed BCD.
// - Seconds: BCD tens 0-5 ones 0-9, binary up to 3Bh.
// - Minutes: BCD tens 0-5, ones 0-9.
// - Hours 24-hour: BCD tens 0-2, binary up to 17h.
// - Weekday 1-7 in low nibble, 0000 reserved, upper bits read zero.
// - Month day from 01h: BCD tens 0-3, binary up to 1Fh.
// - Registers sit in I/O space on the address and data bus.
// - 24-hour time; month day wraps after 31 in every month, no leap-year correction.
// - Reading clock control clears the alarm flag and its interrupt.
`ifndef RTC_CORE_REGS_VH
`define RTC_CORE_REGS_VH
// ==========================================================
// Offsets
`define S_COUNT_ADDR     16'h00E0
`define M_COUNT_ADDR     16'h00E1
`define HOUR_COUNT_ADDR  16'h00E2
`define WEEKDAY_ADDR     16'h00E3
`define MONTHDAY_ADDR    16'h00E4
`define CLK_CTRL_ADDR    16'h00ED
// ==========================================================
// Clock control fields
`define CTRL_UNLOCK_BIT  0
`define CTRL_SRC_BIT     4
`define CTRL_LINE60_BIT  3
`define CTRL_DEC_BIT     2
`define CTRL_ALARM_BIT   7
`define CTRL_RESET       8'h00
// ==========================================================
// Divider counts
`define XTAL_DIV         32768
`define LINE50_DIV       50
`define LINE60_DIV       60
`endif

// ### core/rtc_field_inc.v
// One counted field with binary and BCD wrap.
// Assumes min and max given in the active format.
`timescale 1ns/1ps
`default_nettype none
module rtc_field_inc (
  input  wire [7:0] cur,
  input  wire       dec_en,
  input  wire [7:0] min_val,
  input  wire [7:0] max_val,
  output reg  [7:0] nxt,
  output reg        wrap
);
  always @* begin
    wrap = (cur == max_val);
    if (wrap) begin
      nxt = min_val;
    end else if (dec_en && cur[3:0] == 4'h9) begin
      nxt = {cur[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = cur + 8'h01;
    end
  end
endmodule // rtc_field_inc
`default_nettype wire

// ### bench/rtc_timekeeping_core_monitor.sv
// Port checker for the timekeeping core.
// Assumes counts were written in range before they are read.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_core_regs.vh"
module rtc_timekeeping_core_monitor #(
  parameter XTAL_DIV = 4
) (
  input wire logic        MCLK,
  input wire logic        ARST_N,
  input wire logic        OSC_OUTPUT_PIN,
  input wire logic        IO_SEL,
  input wire logic        IO_WR,
  input wire logic        IO_RD,
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0]  IO_WDATA,
  input wire logic [7:0]  IO_RDATA,
  input wire logic        ALARM_CLEAR
);
  // ==========================================
  // Properties
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  wire logic rd = IO_SEL && IO_RD;
  wire logic rc = rd && IO_ADDR == `CLK_CTRL_ADDR;
  rd_idle_a: assert property (!rd |=> IO_RDATA == 8'h00)
    else $error("read data not idle");
  alm_pulse_a: assert property (rc |=> ALARM_CLEAR)
    else $error("no clear pulse");
  alm_cause_a: assert property (ALARM_CLEAR |-> $past(rc))
    else $error("stray clear pulse");
  sec_max_a: assert property (rd && IO_ADDR == `S_COUNT_ADDR |=>
    IO_RDATA <= 8'h59) else $error("seconds out of range");
  min_max_a: assert property (rd && IO_ADDR == `M_COUNT_ADDR |=>
    IO_RDATA <= 8'h59) else $error("minutes out of range");
  hr_max_a: assert property (rd && IO_ADDR == `HOUR_COUNT_ADDR |=>
    IO_RDATA <= 8'h23) else $error("hours out of range");
  dow_range_a: assert property (rd && IO_ADDR == `WEEKDAY_ADDR |=>
    IO_RDATA inside {[8'h01:8'h07]}) else $error("weekday out of range");
  dom_range_a: assert property (rd && IO_ADDR == `MONTHDAY_ADDR |=>
    IO_RDATA inside {[8'h01:8'h31]}) else $error("month day out of range");
  cover property (rc ##1 ALARM_CLEAR);
  cover property (rd && IO_ADDR == `S_COUNT_ADDR ##1 IO_RDATA == 8'h00);
  cover property (IO_SEL && IO_WR && IO_ADDR == `CLK_CTRL_ADDR);
endmodule // rtc_timekeeping_core_monitor
`default_nettype wire

// ### bench/rtc_timekeeping_core_tb.sv
// Self-checking bench for the timekeeping core.
// Drives bus and source pin at falling edges; small crystal divider.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_core_regs.vh"
module rtc_timekeeping_core_tb;
  localparam int DIV = 4;
  localparam logic [15:0] AD [5] = '{`S_COUNT_ADDR, `M_COUNT_ADDR,
    `HOUR_COUNT_ADDR, `WEEKDAY_ADDR, `MONTHDAY_ADDR};
  logic        mclk, arst_n, pin, sel, wr, rd;
  logic [15:0] addr;
  logic [7:0]  wdata;
  wire logic [7:0] rdata;
  wire logic       alm;
  int failures, checks_done;
  rtc_timekeeping_core #(.XTAL_DIV(DIV)) DUT (.MCLK(mclk), .ARST_N(arst_n),
    .OSC_OUTPUT_PIN(pin), .IO_SEL(sel), .IO_WR(wr), .IO_RD(rd),
    .IO_ADDR(addr), .IO_WDATA(wdata), .IO_RDATA(rdata), .ALARM_CLEAR(alm));
  // ==========================================
  // Bus and pin tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk) {sel, wr, rd, addr, wdata} = {3'b110, a, d};
    @(negedge mclk) {sel, wr} = 2'b00;
  endtask
  // Control data is not compared, only its clear pulse
  task automatic rd8(input logic [15:0] a, input logic [7:0] exp);
    @(negedge mclk) {sel, wr, rd, addr} = {3'b101, a};
    @(negedge mclk) {sel, rd} = 2'b00;
    if (a != `CLK_CTRL_ADDR) chk(rdata, exp);
    chk({7'h00, alm}, {7'h00, a == `CLK_CTRL_ADDR});
  endtask
  task automatic setall(input logic [7:0] v [5]);
    foreach (AD[i]) wr8(AD[i], v[i]);
  endtask
  task automatic chkall(input logic [7:0] v [5]);
    foreach (AD[i]) rd8(AD[i], v[i]);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge mclk) pin = 1'b1;
      repeat (4) @(negedge mclk);
      pin = 1'b0;
      repeat (4) @(negedge mclk);
    end
    repeat (4) @(negedge mclk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_bcd;
    wr8(`CLK_CTRL_ADDR, 8'h05);
    setall('{8'h58, 8'h59, 8'h23, 8'h07, 8'h31});
    pulse(DIV);
    chkall('{8'h58, 8'h59, 8'h23, 8'h07, 8'h31});
    rd8(`CLK_CTRL_ADDR, 8'h00);
    wr8(`CLK_CTRL_ADDR, 8'h04);
    pulse(DIV);
    rd8(`S_COUNT_ADDR, 8'h59);
    pulse(DIV);
    chkall('{8'h00, 8'h00, 8'h00, 8'h01, 8'h01});
    // Ones digit 9 must carry into tens without a field wrap
    wr8(`CLK_CTRL_ADDR, 8'h05);
    wr8(`S_COUNT_ADDR, 8'h59);
    wr8(`M_COUNT_ADDR, 8'h59);
    wr8(`HOUR_COUNT_ADDR, 8'h09);
    wr8(`CLK_CTRL_ADDR, 8'h04);
    pulse(DIV);
    chkall('{8'h00, 8'h00, 8'h10, 8'h01, 8'h01});
    $display("test bcd rollover done");
  endtask
  task automatic t_bin;
    wr8(`CLK_CTRL_ADDR, 8'h01);
    setall('{8'h3B, 8'h3B, 8'h17, 8'h03, 8'h1F});
    wr8(`CLK_CTRL_ADDR, 8'h00);
    pulse(DIV);
    chkall('{8'h00, 8'h00, 8'h00, 8'h04, 8'h01});
    wr8(`S_COUNT_ADDR, 8'h30);
    rd8(`S_COUNT_ADDR, 8'h00);
    $display("test binary rollover done");
  endtask
  task automatic t_reset;
    @(negedge mclk) arst_n = 1'b0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    chkall('{8'h00, 8'h00, 8'h00, 8'h04, 8'h01});
    wr8(`S_COUNT_ADDR, 8'h11);
    pulse(DIV);
    rd8(`S_COUNT_ADDR, 8'h01);
    $display("test reset done");
  endtask
  // Line source: a mid-count control write must restart the divider
  task automatic t_line;
    wr8(`CLK_CTRL_ADDR, 8'h18);
    pulse(30);
    wr8(`CLK_CTRL_ADDR, 8'h18);
    pulse(59);
    rd8(`S_COUNT_ADDR, 8'h01);
    pulse(1);
    rd8(`S_COUNT_ADDR, 8'h02);
    wr8(`CLK_CTRL_ADDR, 8'h10);
    pulse(49);
    rd8(`S_COUNT_ADDR, 8'h02);
    pulse(1);
    rd8(`S_COUNT_ADDR, 8'h03);
    $display("test line source done");
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {arst_n, pin, sel, wr, rd, addr, wdata} = '0;
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    t_bcd();
    t_bin();
    t_reset();
    t_line();
    test_done();
  end
  // About 1650 cycles expected; cut off well beyond
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    test_done();
  end
endmodule // rtc_timekeeping_core_tb
bind rtc_timekeeping_core rtc_timekeeping_core_monitor #(.XTAL_DIV(XTAL_DIV))
  mon (.MCLK, .ARST_N, .OSC_OUTPUT_PIN, .IO_SEL, .IO_WR, .IO_RD, .IO_ADDR,
  .IO_WDATA, .IO_RDATA, .ALARM_CLEAR);
`default_nettype wire
